// *** core/timer0_option.sv ***
// timer with option register, shared prescaler/postscaler and ahb-lite slave
//
// Decided for this implementation: the AHB-Lite slave port.
`default_nettype none
// Operation
// - one prescaler serves timer or watchdog, never both at once
// - timer divides by 2^(rate+1); watchdog divides by 2^rate
// - with prescaler on watchdog, timer counts every selected clock event
// - source bit 1 clocks from external pin, 0 from instruction clock
// - edge bit 1 counts falling pin edges, 0 counts rising
// - interrupt edge bit 1 rising, 0 falling edge of interrupt pin
// - pull-up bit 1 disables all pull-ups, 0 follows port latches
// - timer write clears prescaler when assigned to timer, assignment kept
// - option register read/write, all ones after reset
// - option register decoded at two addresses, same storage
// - without prescaler the clock input itself is the prescaler output
// - prescaler output sampled on second and fourth phase clocks
module timer0_option #(
    parameter int unsigned TIMER_W = tmr_pkg::TIMER_W,
    parameter int unsigned PRE_W = tmr_pkg::PRE_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic timer_ext_clock_pin,
    input wire logic ext_interrupt_pin,
    input wire logic watchdog_raw_tick,
    input wire logic watchdog_clear,
    output logic [7:0] port_b_pullup_enable,
    output logic ext_irq_event,
    output logic ext_irq_flag,
    output logic watchdog_timeout,
    output logic timer_overflow,
    output logic instruction_clock_out
);
    import tmr_pkg::*;

    bus_req_t req, next_req;
    logic rd_pend, next_rd_pend;
    logic next_hreadyout;
    logic [31:0] next_hrdata;
    logic [7:0] read_value;
    logic wr_op, wr_option, wr_timer, wr_status, wr_latch;
    logic [7:0] wr_data;
    option_t option, next_option;
    logic [7:0] latch, next_latch;
    logic [TIMER_W-1:0] count, next_count;
    logic next_overflow, next_irq_flag;
    phase_t phase, next_phase;
    logic insn_level, next_insn_out;
    logic src_level, src_prev, src_rise;
    logic pre_event, pre_clear, pre_out;
    logic [PRE_W-1:0] pre_cnt, rate_mask;
    logic sync1, sync2, sync3, next_sync1, timer_tick;
    logic wd_hit, irq_pin_prev, irq_edge;
    logic [7:0] next_pullup;

    // address phase capture; reads get one wait state so data is registered
    always_comb
    begin
        next_req = req;
        next_rd_pend = 1'b0;
        next_hreadyout = hreadyout;
        next_hrdata = hrdata;
        if (hready)
        begin
            next_req.valid = hsel && htrans[1] && (hsize == HSIZE_WORD);
            next_req.write = hwrite;
            next_req.idx = haddr[ADDR_LSB +: IDX_W];
            if (next_req.valid && !hwrite)
            begin
                next_rd_pend = 1'b1;
                next_hreadyout = 1'b0;
            end
        end
        if (rd_pend)
        begin
            next_hrdata = {24'h000000, read_value};
            next_hreadyout = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req <= '0;
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end
        else
        begin
            req <= next_req;
            rd_pend <= next_rd_pend;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
            hresp <= 1'b0;
        end
    end

    // write decode in the data phase; unmapped writes are dropped
    assign wr_op = req.valid && req.write && hready;
    assign wr_data = hwdata[7:0];
    assign wr_option = wr_op && (req.idx == OPTION_IDX || req.idx == OPTION_ALIAS_IDX);
    assign wr_timer = wr_op && (req.idx == TIMER_IDX);
    assign wr_status = wr_op && (req.idx == STATUS_IDX);
    assign wr_latch = wr_op && (req.idx == LATCH_IDX);

    // read mux, unmapped reads return zero
    always_comb
    begin
        read_value = 8'h00;
        case (req.idx)
            OPTION_IDX, OPTION_ALIAS_IDX: read_value = option;
            TIMER_IDX: read_value = 8'(count);
            LATCH_IDX: read_value = latch;
            STATUS_IDX: read_value = {6'h00, ext_irq_flag, timer_overflow};
            default: read_value = 8'h00;
        endcase
    end

    // option and port latch storage
    always_comb
    begin
        next_option = option;
        next_latch = latch;
        if (wr_option)
            next_option = option_t'(wr_data);
        if (wr_latch)
            next_latch = wr_data;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            option <= option_t'(OPTION_RST);
            latch <= LATCH_RST;
        end
        else
        begin
            option <= next_option;
            latch <= next_latch;
        end
    end

    // phase clocks and instruction clock, high in the last two phases
    always_comb
    begin
        case (phase)
            PH_Q1: next_phase = PH_Q2;
            PH_Q2: next_phase = PH_Q3;
            PH_Q3: next_phase = PH_Q4;
            PH_Q4: next_phase = PH_Q1;
            default: next_phase = PH_Q1;
        endcase
        insn_level = (phase == PH_Q3) || (phase == PH_Q4);
        next_insn_out = (next_phase == PH_Q3) || (next_phase == PH_Q4);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase <= PH_Q1;
            instruction_clock_out <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            instruction_clock_out <= next_insn_out;
        end
    end

    // clock source and edge select; inverted pin makes falling edges count
    assign src_level = option.timer_clock_source_select ?
        (timer_ext_clock_pin ^ option.timer_source_edge_select) : insn_level;
    assign src_rise = src_level && !src_prev;

    // shared prescaler: fed by watchdog ticks or timer clock edges
    assign pre_event = option.prescaler_assign ? watchdog_raw_tick : src_rise;
    assign pre_clear = (wr_timer && !option.prescaler_assign)
        || (watchdog_clear && option.prescaler_assign)
        || (wr_option && (wr_data[3] != option.prescaler_assign));

    prescaler_div #(
        .W(PRE_W)
    ) u_prescaler (
        .clk(hclk),
        .rst_n(hresetn),
        .event_in(pre_event),
        .clear(pre_clear),
        .count(pre_cnt)
    );

    // bypass when the watchdog owns the prescaler
    assign pre_out = option.prescaler_assign ? src_level
        : pre_cnt[option.prescaler_rate_select];

    // sampling on q2 and q4, then edge detect on the sampled level
    always_comb
    begin
        next_sync1 = sync1;
        if (phase == PH_Q2 || phase == PH_Q4)
            next_sync1 = pre_out;
    end
    assign timer_tick = sync2 && !sync3;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            src_prev <= 1'b1; // idle level of the reset source, no false edge
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
        end
        else
        begin
            src_prev <= src_level;
            sync1 <= next_sync1;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // timer count and overflow flag; a set beats a same-cycle clear
    always_comb
    begin
        next_count = count;
        next_overflow = timer_overflow;
        if (wr_status && wr_data[OVF_BIT])
            next_overflow = 1'b0;
        if (wr_timer)
            next_count = TIMER_W'(wr_data);
        else if (timer_tick)
        begin
            next_count = TIMER_W'(count + 1'b1);
            if (&count)
                next_overflow = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= TIMER_W'(TIMER_RST);
            timer_overflow <= 1'b0;
        end
        else
        begin
            count <= next_count;
            timer_overflow <= next_overflow;
        end
    end

    // watchdog postscaler, undivided when the timer owns the prescaler
    assign rate_mask = PRE_W'((PRE_W'(1) << option.prescaler_rate_select) - 1'b1);
    assign wd_hit = watchdog_raw_tick && (!option.prescaler_assign || ((pre_cnt & rate_mask) == rate_mask));

    // external interrupt edge and pull-up gating
    always_comb
    begin
        irq_edge = option.ext_irq_edge_select ? (ext_interrupt_pin && !irq_pin_prev)
            : (!ext_interrupt_pin && irq_pin_prev);
        next_irq_flag = ext_irq_flag;
        if (wr_status && wr_data[IRQ_BIT])
            next_irq_flag = 1'b0;
        if (irq_edge)
            next_irq_flag = 1'b1;
        next_pullup = option.port_b_pullup_disable ? 8'h00 : latch;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_pin_prev <= 1'b0;
            ext_irq_event <= 1'b0;
            ext_irq_flag <= 1'b0;
            watchdog_timeout <= 1'b0;
            port_b_pullup_enable <= 8'h00;
        end
        else
        begin
            irq_pin_prev <= ext_interrupt_pin;
            ext_irq_event <= irq_edge;
            ext_irq_flag <= next_irq_flag;
            watchdog_timeout <= wd_hit;
            port_b_pullup_enable <= next_pullup;
        end
    end

    // checks
    a_option_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_option |=> option == $past(hwdata[7:0])) else $error("option write not stored");
    a_alias_reach: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_op && req.idx == OPTION_ALIAS_IDX |=> option == $past(hwdata[7:0])) else $error("alias miss");
    a_watchdog_owns: assert property (@(posedge hclk) disable iff (!hresetn)
        option.prescaler_assign && !watchdog_raw_tick && !pre_clear |=> $stable(pre_cnt))
        else $error("timer edge moved watchdog prescaler");
    a_sample_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        !(phase == PH_Q2 || phase == PH_Q4) |=> $stable(sync1)) else $error("sampled off phase");
    a_write_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_timer && !option.prescaler_assign |=> pre_cnt == '0) else $error("prescaler not cleared");
    a_assign_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_timer |=> $stable(option.prescaler_assign)) else $error("assignment changed");
    a_wrap_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_tick && !wr_timer && &count |=> count == '0 && timer_overflow) else $error("wrap flag");
    a_direct_count: assert property (@(posedge hclk) disable iff (!hresetn)
        option.prescaler_assign && timer_tick && !wr_timer |=> count == TIMER_W'($past(count) + 1'b1))
        else $error("missed direct count");
    a_irq_rising: assert property (@(posedge hclk) disable iff (!hresetn)
        option.ext_irq_edge_select && ext_interrupt_pin && !irq_pin_prev |=> ext_irq_event ##1 !ext_irq_event)
        else $error("rising interrupt edge lost");
    a_pullup_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        option.port_b_pullup_disable |=> port_b_pullup_enable == 8'h00) else $error("pull-up not disabled");
    a_watchdog_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        option.prescaler_assign && option.prescaler_rate_select == 3'h0 && watchdog_raw_tick
        |=> watchdog_timeout) else $error("watchdog 1:1 missed");
endmodule
`default_nettype wire

// *** core/tmr_pkg.sv ***
// shared constants, register map and types for the shared-prescaler timer
`default_nettype none
package tmr_pkg;
    // widths of the counters
    localparam int unsigned TIMER_W = 8;
    localparam int unsigned PRE_W = 8;
    localparam int unsigned DATA_W = 8;
    // register indices, byte address is four times the index
    localparam int unsigned ADDR_LSB = 2;
    localparam int unsigned IDX_W = 10;
    localparam logic [9:0] OPTION_IDX = 10'h081;
    localparam logic [9:0] OPTION_ALIAS_IDX = 10'h181;
    localparam logic [9:0] TIMER_IDX = 10'h001;
    localparam logic [9:0] LATCH_IDX = 10'h006;
    localparam logic [9:0] STATUS_IDX = 10'h00b;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // values after reset
    localparam logic [7:0] OPTION_RST = 8'hff;
    localparam logic [7:0] TIMER_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    // status bit positions, write one to clear
    localparam int unsigned OVF_BIT = 0;
    localparam int unsigned IRQ_BIT = 1;
    // option field layout, msb first
    typedef struct packed {
        logic port_b_pullup_disable;
        logic ext_irq_edge_select;
        logic timer_clock_source_select;
        logic timer_source_edge_select;
        logic prescaler_assign;
        logic [2:0] prescaler_rate_select;
    } option_t;
    // captured address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [IDX_W-1:0] idx;
    } bus_req_t;
    // internal phase clocks of one instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;
endpackage
`default_nettype wire

// *** core/prescaler_div.sv ***
// clearable ripple-free event counter used as the shared prescaler
`default_nettype none
module prescaler_div #(
    parameter int unsigned W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic event_in,
    input wire logic clear,
    output logic [W-1:0] count
);
    logic [W-1:0] next_count;

    // clear wins over a counted event
    always_comb
    begin
        next_count = count;
        if (clear)
            next_count = '0;
        else if (event_in)
            next_count = W'(count + 1'b1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else
            count <= next_count;
    end
endmodule
`default_nettype wire

// *** test/ext_clock_source.sv ***
// external clock source model driving the timer clock pin
`default_nettype none
module ext_clock_source (
    input wire logic clk,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // pin idles low between bursts
    initial pin = 1'b0;
    // n pulses, high held three clocks, low held four clocks between pulses
    task automatic send(input int n);
        repeat (n)
        begin
            @(posedge clk) pin <= 1'b1;
            repeat (3) @(posedge clk);
            pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// *** test/timer0_shared_prescaler_option_tb.sv ***
// self-checking testbench for the shared-prescaler timer
`default_nettype none
module timer0_shared_prescaler_option_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tmr_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic ext_interrupt_pin = 1'b0;
    logic watchdog_raw_tick = 1'b0;
    logic watchdog_clear = 1'b0;
    logic hready, hreadyout, hresp, pin, ext_irq_event, ext_irq_flag, watchdog_timeout, timer_overflow;
    logic [31:0] hrdata, rd;
    logic [7:0] port_b_pullup_enable;
    logic instruction_clock_out;
    int miscompares = 0;
    int samples_checked = 0;
    int irqs = 0;
    int wdts = 0;
    int cycles = 0;
    int seed = 32'h7857;
    int opt_m, latch_m, a, n, m;
    // the one slave's hreadyout is the bus hready
    assign hready = hreadyout;
    timer0_option i_timer0_option (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_ext_clock_pin(pin),
        .ext_interrupt_pin(ext_interrupt_pin), .watchdog_raw_tick(watchdog_raw_tick),
        .watchdog_clear(watchdog_clear), .port_b_pullup_enable(port_b_pullup_enable),
        .ext_irq_event(ext_irq_event), .ext_irq_flag(ext_irq_flag), .watchdog_timeout(watchdog_timeout),
        .timer_overflow(timer_overflow), .instruction_clock_out(instruction_clock_out));
    ext_clock_source i_ext_clock_source (.clk(hclk), .pin(pin));
    // 40 mhz clock
    initial forever #12.5 hclk = ~hclk;
    // pulse counters and hang guard
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (ext_irq_event === 1'b1) irqs <= irqs + 1;
        if (watchdog_timeout === 1'b1) wdts <= wdts + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end
    task automatic results;
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_rdy;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask
    // one single word transfer, read data left in rd
    task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= HSIZE_WORD;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    // timer count difference over a span of clocks between two reads
    task automatic span(input int k);
        bus(0, TIMER_IDX, 0);
        n = rd[7:0];
        repeat (k - 3) @(posedge hclk);
        bus(0, TIMER_IDX, 0);
        m = (rd - n) & 32'hff;
    endtask
    // watchdog raw ticks two clocks apart
    task automatic tick(input int k);
        repeat (k)
        begin
            watchdog_raw_tick <= 1'b1;
            @(posedge hclk);
            watchdog_raw_tick <= 1'b0;
            @(posedge hclk);
        end
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // no pin edge yet, so nothing counted
        bus(0, TIMER_IDX, 0);
        chk(rd, 32'h0);
        bus(0, OPTION_IDX, 0);
        chk(rd, 32'hff);
        chk(hresp, 1'b0);
        bus(0, OPTION_ALIAS_IDX, 0);
        chk(rd, 32'hff);
        bus(1, OPTION_ALIAS_IDX, 32'h5a);
        bus(0, OPTION_IDX, 0);
        chk(rd, 32'h5a);
        bus(0, 10'h3f0, 0);
        chk(rd, 32'h0);
        // instruction clock high two phases out of four
        n = 0;
        repeat (4)
        begin
            @(posedge hclk);
            n += instruction_clock_out;
        end
        chk(n, 2);
        $display("done: option register");
        latch_m = $random(seed) & 8'hff;
        bus(1, LATCH_IDX, latch_m);
        for (a = 0; a < 2; a++)
        begin
            opt_m = a << 7;
            bus(1, OPTION_IDX, opt_m);
            repeat (2) @(posedge hclk);
            chk({24'h0, port_b_pullup_enable}, opt_m[7] ? 0 : latch_m);
        end
        $display("done: pull-ups");
        for (a = 0; a < 2; a++)
        begin
            bus(1, OPTION_IDX, a << 6);
            bus(1, STATUS_IDX, 32'h1 << IRQ_BIT);
            n = irqs;
            ext_interrupt_pin <= 1'b1;
            repeat (4) @(posedge hclk);
            chk(irqs - n, a);
            chk(ext_irq_flag, a);
            ext_interrupt_pin <= 1'b0;
            repeat (4) @(posedge hclk);
            chk(irqs - n, 1);
            chk(ext_irq_flag, 1'b1);
        end
        $display("done: interrupt edge");
        for (a = 0; a < 8; a++)
        begin
            bus(1, OPTION_IDX, a);
            // a rate switch may give one extra edge; let it land first
            repeat (8) @(posedge hclk);
            span(16 << a);
            chk(m, 2);
        end
        bus(1, OPTION_IDX, 8'h08);
        repeat (8) @(posedge hclk);
        span(400);
        chk(m, 100);
        $display("done: internal clock rates");
        for (a = 0; a < 2; a++)
        begin
            bus(1, OPTION_IDX, 8'h28 | (a << 4));
            repeat (8) @(posedge hclk);
            bus(0, TIMER_IDX, 0);
            n = rd[7:0];
            m = 1 + ($random(seed) & 7);
            i_ext_clock_source.send(m);
            repeat (8) @(posedge hclk);
            bus(0, TIMER_IDX, 0);
            chk((rd - n) & 32'hff, m);
        end
        $display("done: external clock");
        bus(1, OPTION_IDX, 8'h07);
        repeat (300) @(posedge hclk);
        bus(1, TIMER_IDX, 8'h10);
        // first divided edge comes 128 events after the clear, an uncleared one sooner
        repeat (400) @(posedge hclk);
        bus(0, TIMER_IDX, 0);
        chk(rd, 32'h10);
        repeat (200) @(posedge hclk);
        bus(0, TIMER_IDX, 0);
        chk(rd, 32'h11);
        bus(0, OPTION_IDX, 0);
        chk(rd, 32'h07);
        bus(1, STATUS_IDX, 32'h1 << OVF_BIT);
        bus(1, OPTION_IDX, 8'h08);
        bus(1, TIMER_IDX, 8'hfd);
        chk(timer_overflow, 1'b0);
        repeat (30) @(posedge hclk);
        chk(timer_overflow, 1'b1);
        bus(0, STATUS_IDX, 0);
        chk(rd[OVF_BIT], 1'b1);
        bus(1, STATUS_IDX, 32'h1 << OVF_BIT);
        @(posedge hclk);
        chk(timer_overflow, 1'b0);
        $display("done: timer write and overflow");
        for (a = 0; a < 8; a++)
        begin
            bus(1, OPTION_IDX, 8'h08 | a);
            watchdog_clear <= 1'b1;
            @(posedge hclk);
            watchdog_clear <= 1'b0;
            @(posedge hclk);
            n = wdts;
            tick(2 << a);
            repeat (4) @(posedge hclk);
            chk(wdts - n, 2);
        end
        bus(1, OPTION_IDX, 8'h07);
        n = wdts;
        tick(3);
        repeat (4) @(posedge hclk);
        chk(wdts - n, 3);
        $display("done: watchdog postscaler");
        results();
    end
endmodule
`default_nettype wire
